// File: rtl/sms_pkg.sv
// Constants, types and carriers for the operating-mode sequencer
package sms_pkg;

  typedef enum logic [2:0] {
    MD_INIT     = 3'h0,
    MD_NORMAL   = 3'h1,
    MD_STOP     = 3'h2,
    MD_SLEEP    = 3'h3,
    MD_RESTART  = 3'h4,
    MD_FAILSAFE = 3'h5
  } sms_mode_t;

  typedef enum logic [2:0] {
    TG_MODE    = 3'h0,
    TG_WDOG    = 3'h1,
    TG_HWCTRL  = 3'h2,
    TG_SYSSTAT = 3'h3,
    TG_STATCLR = 3'h4,
    TG_TRX     = 3'h5,
    TG_OTHER   = 3'h6
  } sms_target_t;

  // Decoded command frame from the serial link
  typedef struct packed {
    logic        isWrite;
    logic        illegal;
    sms_target_t target;
    logic [7:0]  data;
  } sms_cmd_t;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic       testPinN;
    logic       supplyAboveRt;
    logic       startupOk;
    logic       overTemp2;
    logic       supplyShort;
    logic [3:0] wake;
  } sms_pins_t;

  typedef struct packed {
    sms_mode_t  mode;
    logic [1:0] modeField;
    logic       spiErr;
    logic       wakeIrq;
    logic       wdFail;
    logic       uvFlag;
    logic       testStatus;
    logic       cfgState;
  } sms_status_t;

  // Mode field encodings
  localparam logic [1:0] FLD_NORMAL  = 2'h0;
  localparam logic [1:0] FLD_SLEEP   = 2'h1;
  localparam logic [1:0] FLD_STOP    = 2'h2;
  localparam logic [1:0] FLD_SOFTRST = 2'h3;

  // Field positions in command data
  localparam int MODE_LSB     = 0;
  localparam int WD_LIMIT_BIT = 5;
  localparam int HW_FAIL_OUTPUT_TEST_ON_BIT = 0;
  localparam int HW_AUX_BIT   = 1;
  localparam int HW_WATCHDOG_FAIL_COUNT_SELECT_BIT  = 2;
  localparam int TRX_ON_BIT   = 0;

  // Reset values
  localparam logic WATCHDOG_FAIL_COUNT_SELECT_RESET  = 1'h1;
  localparam logic LIMIT_RESET = 1'h0;

  // Timing
  localparam int CLK_MHZ      = 100;
  localparam int RD_TIME_US   = 10;
  localparam int RD_CYCLES    = RD_TIME_US * CLK_MHZ;
  localparam int LW_TIME_MS   = 200;
  localparam int LW_CYCLES    = LW_TIME_MS * 1000 * CLK_MHZ;
  localparam int WD_TIME_MS   = 20;
  localparam int WD_CYCLES    = WD_TIME_MS * 1000 * CLK_MHZ;
  localparam int MAX_WD_RESET = 3;

endpackage

// File: rtl/sms_sync.sv
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ns
`default_nettype none
module sms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: rtl/sms_mode_sequencer.sv
// Operating-mode sequencer with reset, watchdog and link command intake
`timescale 1ns/1ns
`default_nettype none
module sms_mode_sequencer #(
  parameter int LongWindowCycles = sms_pkg::LW_CYCLES,
  parameter int WdPeriodCycles   = sms_pkg::WD_CYCLES
) (
  // Core clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Link domain
  input  wire logic              spiClk,
  input  wire logic              linkReset,
  input  wire logic              spiFrameDone,
  input  wire sms_pkg::sms_cmd_t spiFrame,
  // Pins
  input  wire sms_pkg::sms_pins_t pins,
  // Reset and supplies
  output logic                   resetOutN,
  output logic                   mainSupplyEn,
  output logic                   auxSupplyEn,
  // Transceivers
  output logic                   xcvrOn,
  output logic                   xcvrWakeCap,
  // Fail outputs
  output logic                   failOutActive,
  output logic                   failSafeInActive,
  // Status
  output sms_pkg::sms_status_t   status
);

  // Link side: hold the frame and flip a toggle
  sms_pkg::sms_cmd_t linkCmd_q;
  logic              linkTog_q;

  always_ff @(posedge spiClk) begin
    if (spiFrameDone) begin
      linkCmd_q <= spiFrame;
    end
  end

  always_ff @(posedge spiClk) begin
    if (linkReset) begin
      linkTog_q <= 1'b0;
    end else if (spiFrameDone) begin
      linkTog_q <= ~linkTog_q;
    end
  end

  // Core side crossings
  logic              togSync;
  logic              togSeen_q;
  sms_pkg::sms_pins_t pinS;

  sms_sync #(.W(1)) u_togSync (
    .clk   (clk),
    .reset (reset),
    .din   (linkTog_q),
    .dout  (togSync)
  );

  sms_sync #(.W($bits(sms_pkg::sms_pins_t))) u_pinSync (
    .clk   (clk),
    .reset (reset),
    .din   (pins),
    .dout  (pinS)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      togSeen_q <= 1'b0;
    end else begin
      togSeen_q <= togSync;
    end
  end

  // State
  sms_pkg::sms_mode_t mode_q;
  sms_pkg::sms_mode_t mode_d;
  logic [1:0]  modeField_q;
  logic [15:0] rdCnt_q;
  logic [31:0] wdCnt_q;
  logic        wdRun_q;
  logic        miss_q;
  logic [1:0]  rstCnt_q;
  logic        devMode_q;
  logic        softRstSeen_q;
  logic        poweredUp_q;
  logic [3:0]  wakePrev_q;
  logic        limitEn_q;
  logic        watchdog_fail_count_select_q;
  logic        foTest_q;
  logic        foLatch_q;
  logic        spiErr_q;
  logic        wakeIrq_q;
  logic        wdFail_q;
  logic        uvFlag_q;

  // Command decode
  sms_pkg::sms_cmd_t cmd;
  logic       cmdV;
  logic [1:0] reqFld;
  logic       isModeW;
  logic       stopAllowed;
  logic       stopReject;
  logic       sleepFromStop;
  logic       cfgWrite;
  logic       wdRefresh;
  logic       statClr;
  logic       softRst;
  logic       rdDone;
  logic       wakeEv;
  logic       critical;
  logic       wdExpire;
  logic       wdReset;
  logic       wdStart;
  logic       enterRestart;

  always_comb begin
    cmd     = linkCmd_q;
    // Restart, sleep and fail-safe do not interpret the link
    cmdV    = (togSync ^ togSeen_q) && (mode_q == sms_pkg::MD_INIT
            || mode_q == sms_pkg::MD_NORMAL || mode_q == sms_pkg::MD_STOP);
    reqFld  = cmd.data[sms_pkg::MODE_LSB +: 2];
    isModeW = cmdV && cmd.isWrite && cmd.target == sms_pkg::TG_MODE;
    stopAllowed = !cmd.isWrite
      || cmd.target == sms_pkg::TG_WDOG
      || cmd.target == sms_pkg::TG_SYSSTAT
      || cmd.target == sms_pkg::TG_STATCLR
      || (cmd.target == sms_pkg::TG_MODE
          && (reqFld == sms_pkg::FLD_NORMAL || reqFld == sms_pkg::FLD_SOFTRST));
    stopReject    = cmdV && mode_q == sms_pkg::MD_STOP && !stopAllowed;
    sleepFromStop = stopReject && isModeW && reqFld == sms_pkg::FLD_SLEEP;
    // Configuration frozen outside init and normal
    cfgWrite  = cmdV && cmd.isWrite && !cmd.illegal
             && (mode_q == sms_pkg::MD_NORMAL || mode_q == sms_pkg::MD_INIT);
    wdRefresh = cmdV && cmd.isWrite && cmd.target == sms_pkg::TG_WDOG;
    statClr   = cmdV && cmd.isWrite && cmd.target == sms_pkg::TG_STATCLR;
    softRst   = isModeW && reqFld == sms_pkg::FLD_SOFTRST;
    rdDone    = pinS.supplyAboveRt && rdCnt_q == 16'(sms_pkg::RD_CYCLES);
    wakeEv    = |(pinS.wake & ~wakePrev_q);
    critical  = pinS.overTemp2 || pinS.supplyShort;
    wdExpire  = wdRun_q && !devMode_q && wdCnt_q == 32'h0000_0000;
    // First miss or second miss, and optional limit
    wdReset   = wdExpire && (miss_q || watchdog_fail_count_select_q)
             && !(limitEn_q && rstCnt_q == 2'(sms_pkg::MAX_WD_RESET));
    wdStart   = mode_q == sms_pkg::MD_INIT && !resetOutN && rdDone;
  end

  // Mode transitions
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      sms_pkg::MD_INIT: begin
        if (critical) begin
          mode_d = sms_pkg::MD_FAILSAFE;
        end else if (cmdV && !softRst) begin
          mode_d = sms_pkg::MD_NORMAL;
        end
      end
      sms_pkg::MD_NORMAL, sms_pkg::MD_STOP: begin
        if (critical) begin
          mode_d = sms_pkg::MD_FAILSAFE;
        end else if (softRst) begin
          mode_d = sms_pkg::MD_INIT;
        end else if (!pinS.supplyAboveRt || wdReset || sleepFromStop) begin
          mode_d = sms_pkg::MD_RESTART;
        end else if (isModeW && !stopReject) begin
          case (reqFld)
            sms_pkg::FLD_SLEEP: mode_d = sms_pkg::MD_SLEEP;
            sms_pkg::FLD_STOP:  mode_d = sms_pkg::MD_STOP;
            default:            mode_d = sms_pkg::MD_NORMAL;
          endcase
        end
      end
      sms_pkg::MD_SLEEP: begin
        if (wakeEv) begin
          mode_d = sms_pkg::MD_RESTART;
        end
      end
      sms_pkg::MD_RESTART: begin
        if (critical) begin
          mode_d = sms_pkg::MD_FAILSAFE;
        end else if (rdDone) begin
          mode_d = sms_pkg::MD_NORMAL;
        end
      end
      sms_pkg::MD_FAILSAFE: begin
        if (wakeEv && !pinS.overTemp2) begin
          mode_d = sms_pkg::MD_RESTART;
        end
      end
      default: mode_d = sms_pkg::MD_INIT;
    endcase
    enterRestart = mode_d == sms_pkg::MD_RESTART && mode_q != sms_pkg::MD_RESTART;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= sms_pkg::MD_INIT;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Mode field holds the last accepted mode request; cleared to normal on entry to restart
  always_ff @(posedge clk) begin
    if (reset || enterRestart) begin
      modeField_q <= sms_pkg::FLD_NORMAL;
    end else if (isModeW && !stopReject && !softRst && mode_d != sms_pkg::MD_RESTART) begin
      modeField_q <= reqFld;
    end
  end

  // Reset delay counter above the rising threshold
  always_ff @(posedge clk) begin
    if (reset || !pinS.supplyAboveRt || mode_d != mode_q) begin
      rdCnt_q <= 16'h0000;
    end else if (!rdDone) begin
      rdCnt_q <= rdCnt_q + 16'h0001;
    end
  end

  // Reset output
  always_ff @(posedge clk) begin
    if (reset) begin
      resetOutN <= 1'b0;
    end else begin
      case (mode_d)
        sms_pkg::MD_INIT:   resetOutN <= resetOutN || (wdStart && mode_q == mode_d);
        sms_pkg::MD_NORMAL,
        sms_pkg::MD_STOP:   resetOutN <= 1'b1;
        default:            resetOutN <= 1'b0;
      endcase
    end
  end

  // Watchdog
  always_ff @(posedge clk) begin
    if (reset || mode_d == sms_pkg::MD_SLEEP || mode_d == sms_pkg::MD_FAILSAFE
        || mode_d == sms_pkg::MD_RESTART || softRst) begin
      wdRun_q <= 1'b0;
      wdCnt_q <= 32'h0000_0000;
    end else if (wdStart || (mode_q == sms_pkg::MD_RESTART && mode_d == sms_pkg::MD_NORMAL)) begin
      wdRun_q <= 1'b1;
      wdCnt_q <= 32'(LongWindowCycles);
    end else if (wdRefresh || wdExpire) begin
      wdCnt_q <= 32'(WdPeriodCycles);
    end else if (wdRun_q && !devMode_q && wdCnt_q != 32'h0000_0000) begin
      wdCnt_q <= wdCnt_q - 32'h0000_0001;
    end
  end

  // Miss and consecutive reset tracking
  always_ff @(posedge clk) begin
    if (reset || wdRefresh) begin
      miss_q   <= 1'b0;
      rstCnt_q <= 2'h0;
    end else if (wdExpire) begin
      miss_q <= !wdReset;
      if (wdReset) begin
        rstCnt_q <= rstCnt_q + 2'h1;
      end
    end
  end

  // Strap sampled in init only before any soft reset; a set development mode is kept until reset
  always_ff @(posedge clk) begin
    if (reset) begin
      devMode_q     <= 1'b0;
      softRstSeen_q <= 1'b0;
    end else begin
      if (softRst) begin
        softRstSeen_q <= 1'b1;
      end
      if (mode_q == sms_pkg::MD_INIT && cmdV && !softRstSeen_q && !pinS.testPinN) begin
        devMode_q <= 1'b1;
      end
    end
  end

  // Host configuration bits
  always_ff @(posedge clk) begin
    if (reset) begin
      limitEn_q <= sms_pkg::LIMIT_RESET;
      watchdog_fail_count_select_q    <= sms_pkg::WATCHDOG_FAIL_COUNT_SELECT_RESET;
      foTest_q  <= 1'b0;
    end else if (cfgWrite && cmd.target == sms_pkg::TG_WDOG) begin
      limitEn_q <= cmd.data[sms_pkg::WD_LIMIT_BIT];
    end else if (cfgWrite && cmd.target == sms_pkg::TG_HWCTRL) begin
      watchdog_fail_count_select_q   <= cmd.data[sms_pkg::HW_WATCHDOG_FAIL_COUNT_SELECT_BIT];
      foTest_q <= cmd.data[sms_pkg::HW_FAIL_OUTPUT_TEST_ON_BIT];
    end
  end

  // Supplies
  always_ff @(posedge clk) begin
    if (reset) begin
      mainSupplyEn <= 1'b1;
      auxSupplyEn  <= 1'b0;
    end else begin
      mainSupplyEn <= !(mode_d == sms_pkg::MD_FAILSAFE || mode_d == sms_pkg::MD_SLEEP);
      if (mode_d == sms_pkg::MD_FAILSAFE || mode_d == sms_pkg::MD_RESTART
          || mode_d == sms_pkg::MD_INIT) begin
        auxSupplyEn <= 1'b0;
      end else if (cfgWrite && cmd.target == sms_pkg::TG_HWCTRL) begin
        auxSupplyEn <= cmd.data[sms_pkg::HW_AUX_BIT];
      end
    end
  end

  // Transceivers
  always_ff @(posedge clk) begin
    if (reset || mode_d == sms_pkg::MD_INIT) begin
      xcvrOn      <= 1'b0;
      xcvrWakeCap <= 1'b0;
    end else if (enterRestart) begin
      xcvrWakeCap <= xcvrOn || xcvrWakeCap;
      xcvrOn      <= 1'b0;
    end else if (mode_d == sms_pkg::MD_FAILSAFE) begin
      xcvrOn      <= 1'b0;
      xcvrWakeCap <= 1'b1;
    end else if (cfgWrite && cmd.target == sms_pkg::TG_TRX) begin
      xcvrOn      <= cmd.data[sms_pkg::TRX_ON_BIT];
      xcvrWakeCap <= 1'b0;
    end
  end

  // Fail outputs; the fail latch sets only after power-up completes, fail-safe input always active
  always_ff @(posedge clk) begin
    if (reset) begin
      poweredUp_q      <= 1'b0;
      foLatch_q        <= 1'b0;
      failOutActive    <= 1'b0;
      failSafeInActive <= 1'b1;
    end else begin
      if (pinS.supplyAboveRt && pinS.startupOk) begin
        poweredUp_q <= 1'b1;
      end
      if (poweredUp_q && (mode_d == sms_pkg::MD_FAILSAFE || wdReset)) begin
        foLatch_q <= 1'b1;
      end
      failOutActive    <= foLatch_q || (foTest_q && mode_q == sms_pkg::MD_NORMAL);
      failSafeInActive <= 1'b1;
    end
  end

  // Sticky status flags; a set beats a clear
  always_ff @(posedge clk) begin
    if (reset) begin
      spiErr_q   <= 1'b0;
      wakeIrq_q  <= 1'b0;
      wdFail_q   <= 1'b0;
      uvFlag_q   <= 1'b0;
      wakePrev_q <= 4'h0;
    end else begin
      wakePrev_q <= pinS.wake;
      spiErr_q   <= stopReject || (spiErr_q && !statClr);
      // Wakes in init are dropped outright
      wakeIrq_q  <= (wakeEv && (mode_q == sms_pkg::MD_NORMAL
                    || mode_q == sms_pkg::MD_STOP)) || (wakeIrq_q && !statClr);
      wdFail_q   <= wdExpire || (wdFail_q && !statClr);
      uvFlag_q   <= (poweredUp_q && !pinS.supplyAboveRt) || (uvFlag_q && !statClr);
    end
  end

  assign status = '{
    mode:       mode_q,
    modeField:  modeField_q,
    spiErr:     spiErr_q,
    wakeIrq:    wakeIrq_q,
    wdFail:     wdFail_q,
    uvFlag:     uvFlag_q,
    testStatus: devMode_q,
    cfgState:   watchdog_fail_count_select_q
  };

endmodule
`default_nettype wire

// File: verification/sms_host_model.sv
// Host-side link model: queued command frames and periodic watchdog refresh
`timescale 1ns/1ns
`default_nettype none
module sms_host_model (
  // Link clock and reset request
  input  wire logic         spiClk,
  input  wire logic         reset,
  input  wire logic         wdAuto,
  // Frame output
  output logic              linkReset,
  output logic              spiFrameDone,
  output sms_pkg::sms_cmd_t spiFrame
);
  localparam sms_pkg::sms_cmd_t Refresh = '{1'b1, 1'b0, sms_pkg::TG_WDOG, 8'h00};
  sms_pkg::sms_cmd_t q[$];
  int                gap = 0;
  int                tick = 0;
  initial begin
    linkReset = 1'b1;
    spiFrameDone = 1'b0;
    spiFrame = '0;
  end
  task automatic send(input sms_pkg::sms_cmd_t c);
    q.push_back(c);
  endtask
  // Frames spaced at least 9 link cycles (8 idle cycles between); data scrambled between frames
  always @(posedge spiClk) begin
    linkReset <= reset;
    spiFrameDone <= 1'b0;
    tick <= tick + 1;
    if (gap != 0) begin
      gap <= gap - 1;
      spiFrame <= sms_pkg::sms_cmd_t'(~spiFrame);
    end else if (q.size() != 0) begin
      spiFrame <= q.pop_front();
      spiFrameDone <= 1'b1;
      gap <= 8;
    end else if (wdAuto && tick >= 40) begin
      spiFrame <= Refresh;
      spiFrameDone <= 1'b1;
      gap <= 8;
      tick <= 0;
    end else begin
      spiFrame <= sms_pkg::sms_cmd_t'(~spiFrame);
    end
  end
endmodule
`default_nettype wire

// File: verification/sms_mode_sequencer_chk.sv
// Port checker for the operating-mode sequencer
`timescale 1ns/1ns
`default_nettype none
module sms_mode_sequencer_chk #(
  parameter int LongWindowCycles = sms_pkg::LW_CYCLES,
  parameter int WdPeriodCycles   = sms_pkg::WD_CYCLES
) (
  // Core clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // Watched ports
  input wire sms_pkg::sms_pins_t   pins,
  input wire logic                 resetOutN,
  input wire logic                 mainSupplyEn,
  input wire logic                 auxSupplyEn,
  input wire logic                 xcvrOn,
  input wire logic                 xcvrWakeCap,
  input wire logic                 failOutActive,
  input wire logic                 failSafeInActive,
  input wire sms_pkg::sms_status_t status
);
  localparam int      RdCycles = sms_pkg::RD_CYCLES;
  logic [10:0]        upCnt_q;
  logic               seenUp_q;
  sms_pkg::sms_mode_t md;
  assign md = status.mode;
  // Cycles with supply above threshold, raw pin view
  always_ff @(posedge clk) begin
    if (reset || !pins.supplyAboveRt) upCnt_q <= 11'h000;
    else if (upCnt_q != 11'h7FF) upCnt_q <= upCnt_q + 11'h001;
  end
  always_ff @(posedge clk) begin
    if (reset) seenUp_q <= 1'b0;
    else if (pins.supplyAboveRt && pins.startupOk) seenUp_q <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_init_reset_low: assert property (md == sms_pkg::MD_INIT && upCnt_q < RdCycles |-> !resetOutN)
    else $error("reset output released early");
  a_init_release: assert property (md == sms_pkg::MD_INIT && upCnt_q == RdCycles + 10 |-> resetOutN)
    else $error("reset output not released");
  a_restart_low: assert property (md == sms_pkg::MD_RESTART && $past(md) == sms_pkg::MD_RESTART
    |-> !resetOutN)
    else $error("reset output high in restart");
  a_restart_field: assert property ($past(md) == sms_pkg::MD_RESTART && md == sms_pkg::MD_RESTART
    |-> status.modeField == sms_pkg::FLD_NORMAL)
    else $error("mode field kept in restart");
  a_init_no_wake: assert property (md == sms_pkg::MD_INIT |-> !status.wakeIrq)
    else $error("wake flagged in init");
  a_stop_cfg_frozen: assert property (md == sms_pkg::MD_STOP && $past(md) == sms_pkg::MD_STOP
    |-> $stable(auxSupplyEn) && $stable(xcvrOn) && $stable(xcvrWakeCap))
    else $error("configuration changed in stop");
  a_wake_irq: assert property ((md == sms_pkg::MD_NORMAL || md == sms_pkg::MD_STOP)
    && (pins.wake & ~$past(pins.wake)) != 4'h0 |-> ##[2:8] status.wakeIrq)
    else $error("wake interrupt missing");
  a_wd_restart: assert property ($rose(status.wdFail) && status.cfgState && !status.testStatus
    |-> ##[0:3] md == sms_pkg::MD_RESTART)
    else $error("no restart after watchdog miss");
  a_failsafe_off: assert property (md == sms_pkg::MD_FAILSAFE && $past(md) == sms_pkg::MD_FAILSAFE
    |-> !mainSupplyEn && !resetOutN)
    else $error("supply on in fail-safe");
  a_no_early_fail: assert property (!seenUp_q |-> !status.uvFlag && !failOutActive)
    else $error("flag before power-up");
  a_fsi_active: assert property (failSafeInActive)
    else $error("fail-safe input inactive");
  c_stop: cover property (md == sms_pkg::MD_STOP);
  c_restart: cover property (md == sms_pkg::MD_RESTART);
  c_failsafe: cover property (md == sms_pkg::MD_FAILSAFE);
  c_wake: cover property ($rose(status.wakeIrq));
endmodule
bind sms_mode_sequencer sms_mode_sequencer_chk #(
  .LongWindowCycles(LongWindowCycles),
  .WdPeriodCycles  (WdPeriodCycles)
) u_sms_mode_sequencer_chk (.clk(clk), .reset(reset), .pins(pins), .resetOutN(resetOutN),
  .mainSupplyEn(mainSupplyEn), .auxSupplyEn(auxSupplyEn), .xcvrOn(xcvrOn),
  .xcvrWakeCap(xcvrWakeCap), .failOutActive(failOutActive),
  .failSafeInActive(failSafeInActive), .status(status));
`default_nettype wire

// File: verification/sms_mode_sequencer_tb.sv
// Self-checking bench for the operating-mode sequencer
`timescale 1ns/1ns
`default_nettype none
module sms_mode_sequencer_tb;
  logic                 clk = 1'b0;
  logic                 spiClk = 1'b0;
  logic                 reset = 1'b1;
  logic                 wdAuto = 1'b0;
  logic                 linkReset, spiFrameDone;
  sms_pkg::sms_cmd_t    spiFrame;
  // Test pin high, startup ok, supply low
  sms_pkg::sms_pins_t   pins = 9'h140;
  logic                 resetOutN, mainSupplyEn, auxSupplyEn, xcvrOn, xcvrWakeCap;
  logic                 failOutActive, failSafeInActive;
  sms_pkg::sms_status_t status;
  int                   n_fail = 0;
  int                   compares = 0;
  always #5 clk = ~clk;
  always #6 spiClk = ~spiClk;
  sms_mode_sequencer #(.LongWindowCycles(200), .WdPeriodCycles(100)) u_sms_mode_sequencer (
    .clk(clk), .reset(reset), .spiClk(spiClk), .linkReset(linkReset),
    .spiFrameDone(spiFrameDone), .spiFrame(spiFrame), .pins(pins), .resetOutN(resetOutN),
    .mainSupplyEn(mainSupplyEn), .auxSupplyEn(auxSupplyEn), .xcvrOn(xcvrOn),
    .xcvrWakeCap(xcvrWakeCap), .failOutActive(failOutActive),
    .failSafeInActive(failSafeInActive), .status(status));
  sms_host_model u_sms_host_model (.spiClk(spiClk), .reset(reset), .wdAuto(wdAuto),
    .linkReset(linkReset), .spiFrameDone(spiFrameDone), .spiFrame(spiFrame));
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_mode(input string what, input sms_pkg::sms_mode_t exp,
                          input sms_pkg::sms_mode_t got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input sms_pkg::sms_mode_t m, input int bound);
    for (int i = 0; i < bound && status.mode !== m; i++) cyc(1);
    chk_mode("mode", m, status.mode);
    if (status.mode !== m) finish_test();
  endtask
  task automatic send(input sms_pkg::sms_target_t t, input logic [7:0] d, input logic ill);
    int i;
    u_sms_host_model.send('{1'b1, ill, t, d});
    for (i = 0; i < 200 && (u_sms_host_model.q.size() != 0 || u_sms_host_model.gap != 0); i++)
      cyc(1);
    if (i == 200) begin
      n_fail++;
      finish_test();
    end
    cyc(8);
  endtask
  function automatic sms_pkg::sms_mode_t exp_mode(input sms_pkg::sms_mode_t c,
                                                  input logic [1:0] f);
    if (f == sms_pkg::FLD_STOP && c == sms_pkg::MD_NORMAL) return sms_pkg::MD_STOP;
    if (f == sms_pkg::FLD_SLEEP && c == sms_pkg::MD_STOP) return sms_pkg::MD_RESTART;
    if (f == sms_pkg::FLD_NORMAL) return sms_pkg::MD_NORMAL;
    return c;
  endfunction
  task automatic req_mode(input logic [1:0] f);
    sms_pkg::sms_mode_t e;
    e = exp_mode(status.mode, f);
    send(sms_pkg::TG_MODE, {6'h00, f}, 1'b0);
    wait_mode(e, 50);
  endtask
  task automatic wake_pulse();
    pins.wake = 4'h1 << ($urandom % 4);
    cyc(5);
    pins.wake = 4'h0;
    cyc(8);
  endtask
  initial begin
    void'($urandom(70467));
    cyc(4);
    reset = 1'b0;
    chk_bit("resetOutN", 1'b0, resetOutN);
    chk_bit("cfgState", sms_pkg::WATCHDOG_FAIL_COUNT_SELECT_RESET, status.cfgState);
    wake_pulse();
    chk_bit("wakeIrq", 1'b0, status.wakeIrq);
    pins.supplyAboveRt = 1'b1;
    cyc(sms_pkg::RD_CYCLES - 10);
    chk_bit("resetOutN", 1'b0, resetOutN);
    cyc(20);
    chk_bit("resetOutN", 1'b1, resetOutN);
    $display("test power-up done");
    send(sms_pkg::TG_OTHER, 8'($urandom), 1'b1);
    wait_mode(sms_pkg::MD_NORMAL, 20);
    wdAuto = 1'b1;
    chk_bit("testStatus", 1'b0, status.testStatus);
    chk_bit("auxSupplyEn", 1'b0, auxSupplyEn);
    chk_bit("xcvrOn", 1'b0, xcvrOn);
    chk_bit("failOut", 1'b0, failOutActive);
    send(sms_pkg::TG_HWCTRL, 8'h05, 1'b0);
    chk_bit("failOut", 1'b1, failOutActive);
    send(sms_pkg::TG_HWCTRL, 8'h04, 1'b0);
    chk_bit("failOut", 1'b0, failOutActive);
    send(sms_pkg::TG_TRX, 8'h01, 1'b0);
    chk_bit("xcvrOn", 1'b1, xcvrOn);
    chk_bit("uvFlag", 1'b0, status.uvFlag);
    $display("test normal done");
    req_mode(sms_pkg::FLD_STOP);
    send(sms_pkg::TG_TRX, 8'h00, 1'b0);
    chk_bit("spiErr", 1'b1, status.spiErr);
    chk_bit("xcvrOn", 1'b1, xcvrOn);
    wake_pulse();
    chk_bit("wakeIrq", 1'b1, status.wakeIrq);
    chk_mode("mode", sms_pkg::MD_STOP, status.mode);
    send(sms_pkg::TG_STATCLR, 8'hFF, 1'b0);
    chk_bit("spiErr", 1'b0, status.spiErr);
    req_mode(sms_pkg::FLD_SLEEP);
    chk_bit("spiErr", 1'b1, status.spiErr);
    chk_bit("modeField", 1'b1, status.modeField == sms_pkg::FLD_NORMAL);
    chk_bit("resetOutN", 1'b0, resetOutN);
    chk_bit("xcvrWakeCap", 1'b1, xcvrWakeCap);
    send(sms_pkg::TG_MODE, {6'h00, sms_pkg::FLD_STOP}, 1'b0);
    chk_mode("mode", sms_pkg::MD_RESTART, status.mode);
    wait_mode(sms_pkg::MD_NORMAL, sms_pkg::RD_CYCLES + 100);
    chk_bit("resetOutN", 1'b1, resetOutN);
    $display("test stop done");
    wdAuto = 1'b0;
    wait_mode(sms_pkg::MD_RESTART, 400);
    cyc(2);
    chk_bit("wdFail", 1'b1, status.wdFail);
    chk_bit("failOut", 1'b1, failOutActive);
    chk_bit("mainSupplyEn", 1'b1, mainSupplyEn);
    wdAuto = 1'b1;
    wait_mode(sms_pkg::MD_NORMAL, sms_pkg::RD_CYCLES + 100);
    send(sms_pkg::TG_HWCTRL, 8'h00, 1'b0);
    chk_bit("cfgState", 1'b0, status.cfgState);
    $display("test watchdog done");
    pins.overTemp2 = 1'b1;
    wait_mode(sms_pkg::MD_FAILSAFE, 30);
    chk_bit("mainSupplyEn", 1'b0, mainSupplyEn);
    wake_pulse();
    chk_mode("mode", sms_pkg::MD_FAILSAFE, status.mode);
    pins.overTemp2 = 1'b0;
    wake_pulse();
    wait_mode(sms_pkg::MD_RESTART, 30);
    $display("test fail-safe done");
    wdAuto = 1'b0;
    pins.testPinN = 1'b0;
    reset = 1'b1;
    cyc(4);
    reset = 1'b0;
    chk_mode("mode", sms_pkg::MD_INIT, status.mode);
    cyc(sms_pkg::RD_CYCLES + 20);
    send(sms_pkg::TG_OTHER, 8'($urandom), 1'b0);
    wait_mode(sms_pkg::MD_NORMAL, 20);
    chk_bit("testStatus", 1'b1, status.testStatus);
    cyc(400);
    chk_mode("mode", sms_pkg::MD_NORMAL, status.mode);
    $display("test development done");
    finish_test();
  end
endmodule
`default_nettype wire
